// ===== hdl/tcc_cfg.svh
// tcc_cfg.svh: offsets, field positions, reset values and counts
// assumes: included by the two design files by bare name
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_CHAIN_BIT      7
`define TCC_IRQSEL_BIT     6
`define TCC_MD_LO          2
`define TCC_SZ_BIT         0
`define TCC_MODE_NORMAL    2'h0
`define TCC_MODE_REPEAT    2'h1
`define TCC_MODE_BLOCK     2'h2
`define TCC_EN_RESET       8'h00
`define TCC_NUM_EN_REGS    5
// record word layout in ram: 0 mode_a+src, 1 mode_b+dst, 2 counts
`define TCC_REC_WORDS      3
// host register offsets
`define TCC_REG_EN_A       4'h0
`define TCC_REG_EN_B       4'h1
`define TCC_REG_EN_C       4'h2
`define TCC_REG_EN_D       4'h3
`define TCC_REG_EN_E       4'h4
`define TCC_REG_STATUS     4'h5
`define TCC_REG_REQ        4'h6
`define TCC_REG_RECBASE    4'h7
`define TCC_REG_LAST       4'h8
`endif

// ===== hdl/tcc_pkg.sv
// tcc_pkg: types used by the controller end of the transfer controller
// assumes: tcc_cfg.svh supplies the numeric constants
package tcc_pkg;
    typedef enum logic [1:0] { TCC_NORMAL, TCC_REPEAT, TCC_BLOCK,
                               TCC_BAD } tcc_mode_e;
    typedef enum { TCC_IDLE, TCC_LOAD, TCC_READ, TCC_WRITE, TCC_BACK,
                   TCC_DONE } tcc_state_e;
endpackage : tcc_pkg

// ===== hdl/tcc_link_if.sv
// tcc_link_if: joins the controller with its host-side partner
// assumes: both ends on clk_in; partner drives ram, sources and enables
`timescale 1ns/1ps
interface tcc_link_if;
    logic        req_valid;   // activation from an enabled source
    logic [5:0]  req_vec;     // source index: reg*8 + (7-bit)
    logic        req_ack;     // controller took the request
    logic [39:0] en_bits;     // all enable bits, a in [39:32]
    logic        en_clr;      // pulse: clear enable bit of req_vec
    logic        src_clr;     // pulse: clear source flag of req_vec
    logic        cpu_irq;     // pulse: interrupt the cpu for req_vec
    logic        ram_rd;
    logic        ram_wr;
    logic [7:0]  ram_addr;    // word index of record
    logic [31:0] ram_wdata;
    logic [31:0] ram_rdata;   // valid while ram_rd stands
    logic        bus_rd;
    logic        bus_wr;
    logic        bus_word;
    logic [23:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;   // valid while bus_rd stands
    logic        busy;
    modport ctrl (input req_valid, req_vec, en_bits, ram_rdata, bus_rdata,
                  output req_ack, en_clr, src_clr, cpu_irq, ram_rd, ram_wr,
                  ram_addr, ram_wdata, bus_rd, bus_wr, bus_word, bus_addr,
                  bus_wdata, busy);
    modport host (output req_valid, req_vec, en_bits, ram_rdata, bus_rdata,
                  input req_ack, en_clr, src_clr, cpu_irq, ram_rd, ram_wr,
                  ram_addr, ram_wdata, bus_rd, bus_wr, bus_word, bus_addr,
                  bus_wdata, busy);
endinterface : tcc_link_if

// ===== hdl/tcc_ctrl.sv
// tcc_ctrl: transfer controller engine; loads a register record, moves
// one unit, updates counts, writes the count word back, applies end rules
// assumes: partner answers ram and bus reads in the strobe's cycle
// How it works
// R01: chain bit set continues with next record
// R02: chained unit skips count end and clears
// R03: irq select set: irq every unit, flag kept
// R04: irq select clear: irq only at count end
// R05: mode_b bits 5..0 ignored, written as zero; the code never writes mode_b back
// R06: 24-bit source address gives read address
// R07: word transfers need even source address
// R08: 24-bit destination gives write address, even
// R09: normal mode: 16-bit count, ends at zero
// R10: repeat/block: low byte counts, reloads upper
// R11: block mode: count b ends at zero
// R12: five 8-bit enable registers, fixed sources
// R13: enable bit routes source here, resets zero
// R14: enable cleared on irq-select end or count end
// R15: enable bits map to fixed vectors
// R16: software changes enable bits one at a time
// R17: registers live in ram, loaded and written back; the code writes back only the count word
// R18: mode field 00 normal, 01 repeat, 10 block
// R19: size bit: 0 byte, 1 word
// R20: block mode: count b steps per block
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_ctrl #(
    parameter int REC_AW = 8
) (
    input  wire logic  clk_in,
    input  wire logic  rst_n_in,
    tcc_link_if.ctrl   link,
    input  wire logic [REC_AW-1:0] rec_base_in,  // first record word
    output logic       busy_out
);
    typedef struct packed {
        tcc_pkg::tcc_state_e st;
        logic [7:0]  mode_a;
        logic [7:0]  mode_b;
        logic [23:0] src;
        logic [23:0] dst;
        logic [15:0] cnt_a;
        logic [15:0] cnt_b;
        logic [15:0] data;
        logic [5:0]  vec;
        logic [REC_AW-1:0] rec;
        logic [1:0]  word_ix;
        logic        req_ack;
        logic        en_clr;
        logic        src_clr;
        logic        cpu_irq;
        logic        ram_rd;
        logic        ram_wr;
        logic [REC_AW-1:0] ram_addr;
        logic [31:0] ram_wdata;
        logic        bus_rd;
        logic        bus_wr;
        logic        bus_word;
        logic [23:0] bus_addr;
        logic [15:0] bus_wdata;
        logic        busy;
    } tcc_ctrl_s;

    tcc_ctrl_s st_ff;
    tcc_ctrl_s nxt_st;
    tcc_pkg::tcc_mode_e mode;
    logic        word_sz;
    logic        cnt_end;
    logic [15:0] nxt_cnt_a;
    logic [15:0] nxt_cnt_b;

    // two-bit mode field of mode_a; mode_b low six bits never read
    assign mode    = tcc_pkg::tcc_mode_e'(st_ff.mode_a[`TCC_MD_LO +: 2]); // [R18] [R05]
    assign word_sz = st_ff.mode_a[`TCC_SZ_BIT];                           // [R19]

    always_comb
    begin
        nxt_cnt_a = st_ff.cnt_a;
        nxt_cnt_b = st_ff.cnt_b;
        cnt_end   = 1'b0;
        unique case (mode)
            tcc_pkg::TCC_NORMAL:
            begin
                nxt_cnt_a = st_ff.cnt_a - 16'h0001;                       // [R09]
                cnt_end   = (nxt_cnt_a == 16'h0000);
            end
            tcc_pkg::TCC_REPEAT:
            begin
                nxt_cnt_a[7:0] = st_ff.cnt_a[7:0] - 8'h01;                // [R10]
                if (nxt_cnt_a[7:0] == 8'h00)
                    nxt_cnt_a[7:0] = st_ff.cnt_a[15:8];
            end
            tcc_pkg::TCC_BLOCK:
            begin
                nxt_cnt_a[7:0] = st_ff.cnt_a[7:0] - 8'h01;                // [R10]
                if (nxt_cnt_a[7:0] == 8'h00)
                begin
                    nxt_cnt_a[7:0] = st_ff.cnt_a[15:8];
                    nxt_cnt_b      = st_ff.cnt_b - 16'h0001;              // [R20] [R11]
                    cnt_end        = (nxt_cnt_b == 16'h0000);
                end
            end
            default:
            begin
                cnt_end = 1'b1;  // prohibited mode: stop at once
            end
        endcase
    end

    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.req_ack = 1'b0;
        nxt_st.en_clr  = 1'b0;
        nxt_st.src_clr = 1'b0;
        nxt_st.cpu_irq = 1'b0;
        nxt_st.ram_rd  = 1'b0;
        nxt_st.ram_wr  = 1'b0;
        nxt_st.bus_rd  = 1'b0;
        nxt_st.bus_wr  = 1'b0;
        unique case (st_ff.st)
            tcc_pkg::TCC_IDLE:
            begin
                nxt_st.busy = 1'b0;
                // request only honoured while its enable bit is set
                if (link.req_valid && link.en_bits[6'd39 - link.req_vec]) // [R13] [R15]
                begin
                    nxt_st.req_ack  = 1'b1;
                    nxt_st.busy     = 1'b1;
                    nxt_st.vec      = link.req_vec;
                    nxt_st.rec      = rec_base_in;
                    nxt_st.word_ix  = 2'h0;
                    nxt_st.ram_rd   = 1'b1;
                    nxt_st.ram_addr = rec_base_in;
                    nxt_st.st       = tcc_pkg::TCC_LOAD;
                end
            end
            tcc_pkg::TCC_LOAD:
            begin
                // record fetched from ram, one word a cycle
                unique case (st_ff.word_ix)                               // [R17]
                    2'h0:
                    begin
                        nxt_st.mode_a = link.ram_rdata[31:24];
                        nxt_st.src    = link.ram_rdata[23:0];             // [R06]
                    end
                    2'h1:
                    begin
                        nxt_st.mode_b = link.ram_rdata[31:24];
                        nxt_st.dst    = link.ram_rdata[23:0];             // [R08]
                    end
                    default:
                    begin
                        nxt_st.cnt_a = link.ram_rdata[31:16];
                        nxt_st.cnt_b = link.ram_rdata[15:0];
                    end
                endcase
                if (st_ff.word_ix == 2'h2)
                begin
                    nxt_st.bus_rd   = 1'b1;
                    nxt_st.bus_word = st_ff.mode_a[`TCC_SZ_BIT];          // [R19]
                    nxt_st.bus_addr = st_ff.src;                          // [R06] [R07]
                    nxt_st.st       = tcc_pkg::TCC_READ;
                end
                else
                begin
                    nxt_st.word_ix  = st_ff.word_ix + 2'h1;
                    nxt_st.ram_rd   = 1'b1;
                    nxt_st.ram_addr = st_ff.rec + REC_AW'(st_ff.word_ix) + REC_AW'(1);
                end
            end
            tcc_pkg::TCC_READ:
            begin
                nxt_st.data      = word_sz ? link.bus_rdata
                                           : {8'h00, link.bus_rdata[7:0]};
                nxt_st.bus_wr    = 1'b1;
                nxt_st.bus_addr  = st_ff.dst;                             // [R08]
                nxt_st.bus_wdata = word_sz ? link.bus_rdata
                                           : {8'h00, link.bus_rdata[7:0]};
                nxt_st.st        = tcc_pkg::TCC_WRITE;
            end
            tcc_pkg::TCC_WRITE:
            begin
                nxt_st.cnt_a    = nxt_cnt_a;
                nxt_st.cnt_b    = nxt_cnt_b;
                nxt_st.ram_wr   = 1'b1;                                   // [R17]
                nxt_st.ram_addr = st_ff.rec + REC_AW'(2);
                nxt_st.ram_wdata = {nxt_cnt_a, nxt_cnt_b};
                if (st_ff.mode_b[`TCC_CHAIN_BIT])
                begin
                    // chained: no end check, no flag or enable clear
                    nxt_st.rec      = st_ff.rec + REC_AW'(`TCC_REC_WORDS); // [R01] [R02]
                    nxt_st.st       = tcc_pkg::TCC_BACK;
                end
                else
                begin
                    if (st_ff.mode_b[`TCC_IRQSEL_BIT] || cnt_end)
                        nxt_st.cpu_irq = 1'b1;                            // [R03] [R04]
                    if (st_ff.mode_b[`TCC_IRQSEL_BIT] || cnt_end)
                        nxt_st.en_clr  = 1'b1;                            // [R14]
                    if (!st_ff.mode_b[`TCC_IRQSEL_BIT] && !cnt_end)
                        nxt_st.src_clr = 1'b1;                            // [R03]
                    nxt_st.st = tcc_pkg::TCC_DONE;
                end
            end
            tcc_pkg::TCC_BACK:
            begin
                // move on to the next record of the chain
                nxt_st.word_ix  = 2'h0;
                nxt_st.ram_rd   = 1'b1;
                nxt_st.ram_addr = st_ff.rec;
                nxt_st.st       = tcc_pkg::TCC_LOAD;                      // [R01]
            end
            default:
            begin
                nxt_st.busy = 1'b0;
                nxt_st.st   = tcc_pkg::TCC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st_ff    <= '0;
            st_ff.st <= tcc_pkg::TCC_IDLE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign link.req_ack   = st_ff.req_ack;
    assign link.en_clr    = st_ff.en_clr;
    assign link.src_clr   = st_ff.src_clr;
    assign link.cpu_irq   = st_ff.cpu_irq;
    assign link.ram_rd    = st_ff.ram_rd;
    assign link.ram_wr    = st_ff.ram_wr;
    assign link.ram_addr  = st_ff.ram_addr;
    assign link.ram_wdata = st_ff.ram_wdata;
    assign link.bus_rd    = st_ff.bus_rd;
    assign link.bus_wr    = st_ff.bus_wr;
    assign link.bus_word  = st_ff.bus_word;
    assign link.bus_addr  = st_ff.bus_addr;
    assign link.bus_wdata = st_ff.bus_wdata;
    assign link.busy      = st_ff.busy;
    assign busy_out       = st_ff.busy;
endmodule : tcc_ctrl

// ===== hdl/tcc_host.sv
// tcc_host: host end; holds the five enable registers, turns source
// pulses into requests, applies clears and forwards cpu interrupts
// assumes: software port on clk_in; sources are same-clock pulses
`timescale 1ns/1ps
`include "tcc_cfg.svh"
module tcc_host #(
    parameter int NSRC = 40
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    tcc_link_if.host              link,
    input  wire logic [NSRC-1:0]  src_flag_in,  // source flags, a7 at top
    input  wire logic [3:0]       addr_in,
    input  wire logic [7:0]       wdata_in,
    input  wire logic             wr_in,
    input  wire logic             rd_in,
    input  wire logic [31:0]      ram_rdata_in,
    input  wire logic [15:0]      bus_rdata_in,
    output logic [7:0]            rdata_out,
    output logic [NSRC-1:0]       src_clr_out,
    output logic [NSRC-1:0]       cpu_irq_out,
    output logic [7:0]            rec_base_out
);
    typedef struct packed {
        logic [NSRC-1:0] en;
        logic [NSRC-1:0] clr;
        logic [NSRC-1:0] irq;
        logic [7:0]      rdata;
        logic [7:0]      rec_base;
        logic            req_valid;
        logic [5:0]      req_vec;
    } tcc_host_s;

    tcc_host_s st_ff;
    tcc_host_s nxt_st;
    logic [NSRC-1:0] pend;
    logic [5:0]      pick;
    logic [5:0]      bit_ix;

    // lowest vector wins: highest index in the packed vector
    function automatic logic [5:0] tcc_first(input logic [NSRC-1:0] v);
        logic [5:0] r;
        r = 6'h00;
        for (int i = 0; i < NSRC; i++)
            if (v[i])
                r = 6'(NSRC - 1 - i);
        return r;
    endfunction : tcc_first

    // a flag whose clear is still in flight must not start a second run
    assign pend   = src_flag_in & st_ff.en & ~st_ff.clr;                  // [R13]
    assign pick   = tcc_first(pend);
    assign bit_ix = 6'(NSRC - 1) - link.req_vec;

    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.clr   = '0;
        nxt_st.irq   = '0;
        nxt_st.rdata = 8'h00;
        // enabled sources raise requests instead of cpu interrupts
        if (!st_ff.req_valid && !link.busy && (pend != '0))
        begin
            nxt_st.req_valid = 1'b1;
            nxt_st.req_vec   = pick;                                      // [R15]
        end
        if (link.req_ack)
            nxt_st.req_valid = 1'b0;
        if (wr_in && addr_in < `TCC_REG_STATUS)
            nxt_st.en[(6'd4 - 6'(addr_in)) * 8 +: 8] = wdata_in;          // [R12] [R16]
        if (wr_in && addr_in == `TCC_REG_RECBASE)
            nxt_st.rec_base = wdata_in;
        if (link.en_clr)
            nxt_st.en[bit_ix] = 1'b0;                                     // [R14]
        if (link.src_clr)
            nxt_st.clr[bit_ix] = 1'b1;
        if (link.cpu_irq)
            nxt_st.irq[bit_ix] = 1'b1;
        // unselected sources interrupt the cpu directly
        nxt_st.irq = nxt_st.irq | (src_flag_in & ~st_ff.en);
        if (rd_in)
        begin
            if (addr_in < `TCC_REG_STATUS)
                nxt_st.rdata = st_ff.en[(6'd4 - 6'(addr_in)) * 8 +: 8];
            else if (addr_in == `TCC_REG_STATUS)
                nxt_st.rdata = {7'h00, link.busy};
            else if (addr_in == `TCC_REG_REQ)
                nxt_st.rdata = {st_ff.req_valid, 1'b0, st_ff.req_vec};
            else if (addr_in == `TCC_REG_RECBASE)
                nxt_st.rdata = st_ff.rec_base;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            st_ff <= '0;                                                  // [R13]
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign link.req_valid = st_ff.req_valid;
    assign link.req_vec   = st_ff.req_vec;
    assign link.en_bits   = st_ff.en;
    assign link.ram_rdata = ram_rdata_in;
    assign link.bus_rdata = bus_rdata_in;
    assign rdata_out      = st_ff.rdata;
    assign src_clr_out    = st_ff.clr;
    assign cpu_irq_out    = st_ff.irq;
    assign rec_base_out   = st_ff.rec_base;
endmodule : tcc_host

// ===== testbench/tcc_link_assertions.sv
// tcc_link_assertions: load, move and end rules seen on the link
// assumes: records are three ram words, memory answers while rd stands
`timescale 1ns/1ps
module tcc_link_assertions (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        req_valid,
    input wire logic [5:0]  req_vec,
    input wire logic        req_ack,
    input wire logic [39:0] en_bits,
    input wire logic        en_clr,
    input wire logic        src_clr,
    input wire logic        cpu_irq,
    input wire logic        ram_rd,
    input wire logic        ram_wr,
    input wire logic [31:0] ram_wdata,
    input wire logic [31:0] ram_rdata,
    input wire logic        bus_rd,
    input wire logic        bus_wr,
    input wire logic        bus_word,
    input wire logic [23:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic [15:0] bus_rdata
);
    logic [31:0] d1, d2, d3;
    logic [15:0] bq;
    logic        ok_q;
    logic [1:0]  md;
    logic        chn, dis, done;
    // last three record words read: d3=word0, d2=word1, d1=word2
    always_ff @(posedge clk_in)
    begin
        if (ram_rd)
        begin
            d1 <= ram_rdata;
            d2 <= d1;
            d3 <= d2;
        end
        bq <= bus_rdata;
        ok_q <= req_valid && en_bits[6'd39 - req_vec];
    end
    assign md = d3[27:26];
    assign chn = d2[31];
    assign dis = d2[30];
    assign done = md == 2'h3 || (md == 2'h0 && ram_wdata[31:16] == 16'h0000)
        || (md == 2'h2 && ram_wdata[15:0] == 16'h0000);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    a_ack_loads_rec: assert property (
        req_ack |-> ram_rd ##1 ram_rd ##1 ram_rd ##1 bus_rd ##1 bus_wr
        ##1 ram_wr) else $error("record sequence broken");
    a_ack_needs_en: assert property (
        req_ack |-> ok_q) else $error("request taken while disabled");
    a_src_read: assert property (
        bus_rd |-> bus_addr == d3[23:0]) else $error("read address wrong");
    a_dst_write: assert property (
        bus_wr |-> bus_addr == d2[23:0] && bus_word == d3[24])
        else $error("write address or size wrong");
    a_data_moved: assert property (
        bus_wr |-> bus_wdata[7:0] == bq[7:0]
        && (!bus_word || bus_wdata[15:8] == bq[15:8]))
        else $error("moved data wrong");
    a_chain_quiet: assert property (
        ram_wr && chn |-> !(cpu_irq || en_clr || src_clr))
        else $error("chained unit ended");
    a_chain_next: assert property (
        ram_wr && chn |-> ##[1:3] ram_rd) else $error("chain not followed");
    a_irq_each: assert property (
        ram_wr && !chn && dis |-> cpu_irq && en_clr && !src_clr)
        else $error("irq each unit wrong");
    a_irq_at_end: assert property (
        ram_wr && !chn && !dis |-> cpu_irq == done && en_clr == done)
        else $error("end of count handling wrong");
    a_normal_count: assert property (
        ram_wr && md == 2'h0 |-> ram_wdata[31:16] == d1[31:16] - 16'h0001)
        else $error("normal count wrong");
    a_reload_count: assert property (
        ram_wr && (md == 2'h1 || md == 2'h2) |-> ram_wdata[31:24] == d1[31:24]
        && ram_wdata[23:16] == (d1[23:16] == 8'h01 ? d1[31:24]
        : d1[23:16] - 8'h01)) else $error("reload count wrong");
    a_block_count: assert property (
        ram_wr && md == 2'h2 |-> ram_wdata[15:0] == (d1[23:16] == 8'h01
        ? d1[15:0] - 16'h0001 : d1[15:0])) else $error("block count wrong");
endmodule : tcc_link_assertions

// ===== testbench/testbench.sv
// testbench: both ends joined, bench acts as record ram, bus and cpu
// assumes: record base 8'h10, bus read data is address xor 16'h5A3C
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [39:0] want = '0, gone = '0, irq_seen = '0, clr_seen = '0;
    logic [39:0] src_clr, cpu_irq;
    logic [3:0]  addr_in = 4'h0;
    logic [7:0]  wdata_in = 8'h00, rdata, rec_base;
    logic [31:0] ram_rdata_in, mem [256];
    logic [15:0] bus_rdata_in, wd;
    logic [23:0] wa;
    logic        ww, busy, busy_seen = 1'b0;
    int          nwr = 0, bad_count = 0, num_checks = 0, cyc = 0;
    tcc_link_if link();
    tcc_ctrl i_tcc_ctrl (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
        .rec_base_in(rec_base), .busy_out(busy));
    tcc_host i_tcc_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link),
        .src_flag_in(want & ~gone), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .ram_rdata_in(ram_rdata_in),
        .bus_rdata_in(bus_rdata_in), .rdata_out(rdata),
        .src_clr_out(src_clr), .cpu_irq_out(cpu_irq), .rec_base_out(rec_base));
    tcc_link_assertions i_tcc_link_assertions (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .req_valid(link.req_valid),
        .req_vec(link.req_vec), .req_ack(link.req_ack),
        .en_bits(link.en_bits), .en_clr(link.en_clr), .src_clr(link.src_clr),
        .cpu_irq(link.cpu_irq), .ram_rd(link.ram_rd), .ram_wr(link.ram_wr),
        .ram_wdata(link.ram_wdata), .ram_rdata(link.ram_rdata),
        .bus_rd(link.bus_rd), .bus_wr(link.bus_wr), .bus_word(link.bus_word),
        .bus_addr(link.bus_addr), .bus_wdata(link.bus_wdata),
        .bus_rdata(link.bus_rdata));
    initial forever #5 clk_in = ~clk_in;
    task end_of_test;
        if (bad_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // memories answer while the read strobe stands, inverted junk otherwise
    assign ram_rdata_in = link.ram_rd ? mem[link.ram_addr]
                                      : ~mem[link.ram_addr];
    assign bus_rdata_in = link.bus_rd ? link.bus_addr[15:0] ^ 16'h5A3C
                                      : ~link.bus_addr[15:0] ^ 16'h5A3C;
    always @(posedge clk_in)
    begin
        cyc++;
        irq_seen <= irq_seen | cpu_irq;
        clr_seen <= clr_seen | src_clr;
        gone <= gone | src_clr;
        busy_seen <= busy_seen | busy;
        if (link.ram_wr) mem[link.ram_addr] <= link.ram_wdata;
        if (link.bus_wr)
        begin
            wa <= link.bus_addr;
            wd <= link.bus_wdata;
            ww <= link.bus_word;
            nwr <= nwr + 1;
        end
        if (cyc == 3000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask : wr_reg
    task rd_chk(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 `CHK(n, e, rdata)
    endtask : rd_chk
    // loads one record, enables the source, raises its flag, waits for idle
    task fire(input logic [3:0] ra, input logic [2:0] b,
              input logic [31:0] w0, w1, w2);
        int idx;
        idx = 32 - 8 * ra + b;
        @(posedge clk_in);
        #1;
        mem[16] = w0;
        mem[17] = w1;
        mem[18] = w2;
        {irq_seen, clr_seen, gone} = '0;
        busy_seen = 1'b0;
        nwr = 0;
        wr_reg(ra, 8'h01 << b);
        @(posedge clk_in);
        want[idx] <= 1'b1;
        for (int k = 0; k < 60 && !(busy_seen && !busy); k++) @(posedge clk_in);
        want[idx] <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask : fire
    task t_regs;
        for (int r = 0; r < 5; r++) rd_chk(r[3:0], 8'h00, "en reset");
        wr_reg(4'h2, 8'hA5);
        rd_chk(4'h2, 8'hA5, "en rw");
        wr_reg(4'hF, 8'hFF);
        rd_chk(4'hF, 8'h00, "unmapped");
        rd_chk(4'h5, 8'h00, "status idle");
        rd_chk(4'h6, 8'h00, "no request");
        wr_reg(4'h2, 8'h00);
    endtask : t_regs
    task t_normal;
        fire(4'h0, 3'h7, {8'h00, 24'h001234}, {8'h00, 24'h005678}, 32'h00020000);
        `CHK("count a", 16'h0001, mem[18][31:16])
        `CHK("dst", 24'h005678, wa)
        `CHK("byte", 8'h08, wd[7:0])
        `CHK("flag clr", 1'b1, clr_seen[39])
        `CHK("no irq", 1'b0, irq_seen[39])
        rd_chk(4'h0, 8'h80, "en kept");
        fire(4'h0, 3'h7, {8'h00, 24'h001234}, {8'h00, 24'h005678}, mem[18]);
        `CHK("count end", 16'h0000, mem[18][31:16])
        `CHK("end irq", 1'b1, irq_seen[39])
        rd_chk(4'h0, 8'h00, "en end");
    endtask : t_normal
    task t_irq_each_transfer_select;
        fire(4'h3, 3'h7, {8'h05, 24'h000100}, {8'h7F, 24'h000200},
             32'h04010000);
        `CHK("reload", 16'h0404, mem[18][31:16])
        `CHK("word", 1'b1, ww)
        `CHK("word data", 16'h5B3C, wd)
        `CHK("irq each", 1'b1, irq_seen[15])
        `CHK("flag kept", 1'b0, clr_seen[15])
        rd_chk(4'h3, 8'h00, "en irq_each_transfer_select");
    endtask : t_irq_each_transfer_select
    task t_block;
        fire(4'h4, 3'h0, {8'h09, 24'h000300}, {8'h00, 24'h000400}, 32'h02010001);
        `CHK("block counts", 32'h02020000, mem[18])
        `CHK("block irq", 1'b1, irq_seen[0])
        rd_chk(4'h4, 8'h00, "en block");
    endtask : t_block
    task t_chain;
        mem[19] = {8'h00, 24'h000700};
        mem[20] = {8'h00, 24'h000800};
        mem[21] = 32'h00010000;
        fire(4'h1, 3'h3, {8'h00, 24'h000500}, {8'h80, 24'h000600}, 32'h00010000);
        `CHK("two moves", 2, nwr)
        `CHK("last dst", 24'h000800, wa)
        `CHK("first count", 16'h0000, mem[18][31:16])
        `CHK("chain irq", 1'b1, irq_seen[27])
        rd_chk(4'h1, 8'h00, "en chain");
    endtask : t_chain
    task t_refused;
        @(posedge clk_in);
        #1;
        {irq_seen, gone} = '0;
        busy_seen = 1'b0;
        @(posedge clk_in);
        want[18] <= 1'b1;
        repeat (5) @(posedge clk_in);
        want[18] <= 1'b0;
        `CHK("ignored", 1'b0, busy_seen)
        `CHK("to cpu", 1'b1, irq_seen[18])
    endtask : t_refused
    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wr_reg(4'h7, 8'h10);
        rd_chk(4'h7, 8'h10, "rec base");
        t_regs;
        t_normal;
        t_irq_each_transfer_select;
        t_block;
        t_chain;
        t_refused;
        end_of_test();
    end
endmodule : testbench
